// [logic/gfc_freq_calc.sv]
`timescale 1ns/1ps
module gfc_freq_calc
  import gfc_pkg::*;
(
  gfc_tune_if.calc tif
);
  logic signed [63:0] spacing;
  logic signed [63:0] chan_m1;
  logic signed [63:0] base;

  // frequency in MHz from channel, grid, first channel and fine tune
  always_comb begin
    spacing = 64'(signed'(tif.coarse)) * 64'(MHZ_PER_TENTH) + 64'(signed'(tif.fine)); // RQ2
    chan_m1 = signed'(64'({tif.chan_hi, tif.chan_lo})) - 64'sd1; // RQ1
    base = signed'(64'(tif.thz) * 64'(MHZ_PER_THZ)); // RQ13
    base = base + signed'(64'(tif.tenths) * 64'(MHZ_PER_TENTH)) + signed'(64'(tif.mhz)); // RQ12
    tif.freq = chan_m1 * spacing + base + 64'(signed'(tif.fto)); // RQ1
  end
endmodule : gfc_freq_calc

// [logic/gfc_out_enable.sv]
`timescale 1ns/1ps
module gfc_out_enable (
  input wire logic sw_en,
  input wire logic hw_dis_n,
  input wire logic shutdown_on_fatal,
  input wire logic fatal,
  output logic enabled
);
  // output is lit only with software on, pin high and no fatal shutdown
  assign enabled = sw_en & hw_dis_n & ~(shutdown_on_fatal & fatal); // RQ18
endmodule : gfc_out_enable

// [logic/gfc_pkg.sv]
package gfc_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [9:0] IDX_GRID_COARSE = 10'h034;
  localparam logic [9:0] IDX_FCF_THZ = 10'h035;
  localparam logic [9:0] IDX_FCF_TENTHS = 10'h036;
  localparam logic [9:0] IDX_GRID_FINE = 10'h066;
  localparam logic [9:0] IDX_FCF_MHZ = 10'h067;
  localparam logic [9:0] IDX_CTRL = 10'h070;
  localparam logic [9:0] IDX_CHAN_LO = 10'h071;
  localparam logic [9:0] IDX_CHAN_HI = 10'h072;
  localparam logic [9:0] IDX_FINE_TUNE = 10'h073;
  localparam logic [9:0] IDX_STATUS = 10'h074;
  localparam logic [9:0] IDX_FREQ_BASE = 10'h075;
  localparam int FREQ_WORDS = 4;
  // field positions
  localparam int CTRL_SW_EN_BIT = 0;
  localparam int CTRL_SHUTDOWN_ON_FATAL_BIT = 1;
  localparam int CTRL_TUNE_BIT = 2;
  localparam int STAT_XERR_BIT = 0;
  localparam int STAT_OUT_EN_BIT = 1;
  // reset values
  localparam logic [15:0] RST_GRID_COARSE = 16'h01F4;
  localparam logic [15:0] RST_GRID_FINE = 16'h0000;
  localparam logic [15:0] RST_FCF_THZ = 16'h00C1;
  localparam logic [15:0] RST_FCF_TENTHS = 16'h0000;
  localparam logic [15:0] RST_FCF_MHZ = 16'h0000;
  // unit scaling of the frequency result, in MHz
  localparam int MHZ_PER_THZ = 1000000;
  localparam int MHZ_PER_TENTH = 100;

  typedef struct packed {
    logic [15:0] coarse;
    logic [15:0] fine;
    logic [15:0] thz;
    logic [15:0] tenths;
    logic [15:0] mhz;
    logic [15:0] chan_lo;
    logic [15:0] chan_hi;
    logic [15:0] fto;
    logic sw_en;
    logic shutdown_on_fatal;
    logic xerr;
    logic out_en;
    logic tune_done;
    logic loaded;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [63:0] freq;
  } gfc_state_s;
endpackage : gfc_pkg

// [logic/gfc_regs.sv]
// Functional notes
// RQ1 - frequency = (channel_high*65536 + channel_low - 1)*spacing + first channel + fine tune
// RQ2 - coarse (tenths GHz) and fine (MHz) grid words are signed 16-bit
// RQ3 - host keeps the fine grid word within -99 to +99
// RQ4 - grid writes while output enabled are refused as execution error
// RQ5 - grid write only stores; current frequency does not change
// RQ6 - grid values are consumed only when a tune runs
// RQ7 - coarse and fine grid writes accepted in either order
// RQ8 - any grid value is accepted
// RQ9 - coarse grid resets to a build-time default
// RQ10 - fine grid resets to zero
// RQ11 - saved configuration replaces the built-in defaults
// RQ12 - first channel held as THz, tenths of GHz and MHz words
// RQ13 - first channel words are unsigned 16-bit
// RQ14 - first channel writes while output enabled are refused as execution error
// RQ15 - first channel words accepted in any order
// RQ16 - no error for an inconsistent partial first channel set
// RQ17 - host should program all frequency words before enabling or saving
// RQ18 - output enabled only with software enable, pin high, no fatal shutdown
// RQ19 - refused write leaves register unchanged, answers error with zero data
// RQ20 - accesses complete at once, never pending
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module gfc_regs
  import gfc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hardware_output_disable_n,
  input wire logic fatal_condition_active,
  input wire logic nv_cfg_valid,
  input wire logic [15:0] nv_grid_spacing_coarse,
  input wire logic [15:0] nv_grid_spacing_fine,
  input wire logic [15:0] nv_first_channel_thz,
  input wire logic [15:0] nv_first_channel_ghz_tenths,
  input wire logic [15:0] nv_first_channel_mhz,
  output logic optical_output_enabled,
  output logic [63:0] tuned_freq_mhz,
  output logic tune_done
);
  gfc_state_s st;
  gfc_state_s next_st;
  logic en_now;
  logic [9:0] idx;
  logic is_cfg;
  logic is_freq;
  logic hit;
  logic setup;
  logic wr_commit;
  logic [1:0] freq_sel;
  logic [9:0] freq_off;
  logic [31:0] rd_data;

  gfc_tune_if tif ();

  assign tif.coarse = st.coarse;
  assign tif.fine = st.fine;
  assign tif.thz = st.thz;
  assign tif.tenths = st.tenths;
  assign tif.mhz = st.mhz;
  assign tif.chan_lo = st.chan_lo;
  assign tif.chan_hi = st.chan_hi;
  assign tif.fto = st.fto;

  gfc_freq_calc u_calc (
    .tif(tif.calc)
  );

  gfc_out_enable u_enable (
    .sw_en(st.sw_en),
    .hw_dis_n(hardware_output_disable_n),
    .shutdown_on_fatal(st.shutdown_on_fatal),
    .fatal(fatal_condition_active),
    .enabled(en_now)
  );

  // address decode
  assign idx = paddr[11:2];
  assign setup = psel & ~penable;
  assign wr_commit = psel & penable & st.pready & pwrite & ~st.pslverr;
  assign freq_off = idx - IDX_FREQ_BASE;
  assign freq_sel = freq_off[1:0];
  assign is_freq = (idx >= IDX_FREQ_BASE) && (freq_off < 10'(FREQ_WORDS));
  assign is_cfg = (idx == IDX_GRID_COARSE) || (idx == IDX_GRID_FINE) ||
                  (idx == IDX_FCF_THZ) || (idx == IDX_FCF_TENTHS) || (idx == IDX_FCF_MHZ);

  // read mux and map membership
  always_comb begin
    hit = 1'b1;
    rd_data = 32'h0000_0000;
    if (is_freq) begin
      rd_data[15:0] = st.freq[16 * freq_sel +: 16];
    end else begin
      unique case (idx)
        IDX_GRID_COARSE: rd_data[15:0] = st.coarse;
        IDX_GRID_FINE: rd_data[15:0] = st.fine;
        IDX_FCF_THZ: rd_data[15:0] = st.thz;
        IDX_FCF_TENTHS: rd_data[15:0] = st.tenths;
        IDX_FCF_MHZ: rd_data[15:0] = st.mhz;
        IDX_CHAN_LO: rd_data[15:0] = st.chan_lo;
        IDX_CHAN_HI: rd_data[15:0] = st.chan_hi;
        IDX_FINE_TUNE: rd_data[15:0] = st.fto;
        IDX_CTRL: begin
          rd_data[CTRL_SW_EN_BIT] = st.sw_en;
          rd_data[CTRL_SHUTDOWN_ON_FATAL_BIT] = st.shutdown_on_fatal;
        end
        IDX_STATUS: begin
          rd_data[STAT_XERR_BIT] = st.xerr;
          rd_data[STAT_OUT_EN_BIT] = st.out_en;
        end
        default: hit = 1'b0;
      endcase
    end
  end

  // next state
  always_comb begin
    next_st = st;
    next_st.tune_done = 1'b0;
    next_st.out_en = en_now; // RQ18
    next_st.pready = setup; // RQ20
    next_st.pslverr = 1'b0;
    next_st.prdata = 32'h0000_0000;
    // decided in the setup phase, answered in the access phase
    if (setup) begin
      if (!hit) begin
        next_st.pslverr = 1'b1;
      end else if (pwrite && is_cfg && en_now) begin
        next_st.pslverr = 1'b1; // RQ4 RQ14 RQ19
      end else if (!pwrite) begin
        next_st.prdata = rd_data;
      end
    end
    // writes land only at the access edge, never when refused
    if (wr_commit) begin
      unique case (idx)
        IDX_GRID_COARSE: next_st.coarse = pwdata[15:0]; // RQ5 RQ7 RQ8
        IDX_GRID_FINE: next_st.fine = pwdata[15:0]; // RQ5 RQ7 RQ8
        IDX_FCF_THZ: next_st.thz = pwdata[15:0]; // RQ15 RQ16
        IDX_FCF_TENTHS: next_st.tenths = pwdata[15:0]; // RQ15 RQ16
        IDX_FCF_MHZ: next_st.mhz = pwdata[15:0]; // RQ15 RQ16
        IDX_CHAN_LO: next_st.chan_lo = pwdata[15:0];
        IDX_CHAN_HI: next_st.chan_hi = pwdata[15:0];
        IDX_FINE_TUNE: next_st.fto = pwdata[15:0];
        IDX_CTRL: begin
          next_st.sw_en = pwdata[CTRL_SW_EN_BIT];
          next_st.shutdown_on_fatal = pwdata[CTRL_SHUTDOWN_ON_FATAL_BIT];
          if (pwdata[CTRL_TUNE_BIT]) begin
            next_st.freq = tif.freq; // RQ6 RQ1
            next_st.tune_done = 1'b1;
          end
        end
        IDX_STATUS: begin
          if (pwdata[STAT_XERR_BIT]) begin
            next_st.xerr = 1'b0;
          end
        end
        default: next_st.xerr = st.xerr;
      endcase
    end
    // a new refusal wins over a clear in the same cycle
    if (setup && hit && pwrite && is_cfg && en_now) begin
      next_st.xerr = 1'b1; // RQ4 RQ14
    end
    // saved configuration replaces defaults once after reset
    if (!st.loaded) begin
      next_st.loaded = 1'b1;
      if (nv_cfg_valid) begin
        next_st.coarse = nv_grid_spacing_coarse; // RQ11
        next_st.fine = nv_grid_spacing_fine; // RQ11
        next_st.thz = nv_first_channel_thz; // RQ11
        next_st.tenths = nv_first_channel_ghz_tenths; // RQ11
        next_st.mhz = nv_first_channel_mhz; // RQ11
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.coarse <= RST_GRID_COARSE; // RQ9
      st.fine <= RST_GRID_FINE; // RQ10
      st.thz <= RST_FCF_THZ;
      st.tenths <= RST_FCF_TENTHS;
      st.mhz <= RST_FCF_MHZ;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign optical_output_enabled = st.out_en;
  assign tuned_freq_mhz = st.freq;
  assign tune_done = st.tune_done;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_zero_wait_answer: assert property ( // RQ20
    psel && !penable |=> pready ##1 !pready)
    else $error("answer not given in the access cycle");

  a_error_zero_data: assert property ( // RQ19
    pslverr |-> (prdata == 32'h0000_0000) && pready)
    else $error("error answer carries nonzero data");

  a_refuse_when_lit: assert property ( // RQ4 RQ14
    psel && !penable && pwrite && is_cfg && en_now |=> pslverr && st.xerr)
    else $error("config write while enabled not refused");

  a_refused_no_change: assert property ( // RQ19
    psel && penable && pready && pwrite && pslverr |=>
      $stable(st.coarse) && $stable(st.fine) && $stable(st.thz) &&
      $stable(st.tenths) && $stable(st.mhz))
    else $error("refused write altered a register");

  a_cfg_write_stores: assert property ( // RQ7 RQ8 RQ15
    wr_commit && st.loaded && (idx == IDX_GRID_FINE) |=> st.fine == $past(pwdata[15:0]))
    else $error("fine grid write not stored");

  a_fcf_write_stores: assert property ( // RQ12 RQ16
    wr_commit && st.loaded && (idx == IDX_FCF_TENTHS) |=>
      st.tenths == $past(pwdata[15:0]) && !pslverr)
    else $error("first channel write not stored");

  a_grid_freq_kept: assert property ( // RQ5
    wr_commit && (idx == IDX_GRID_COARSE) |=> $stable(tuned_freq_mhz))
    else $error("grid write moved the frequency");

  a_freq_only_tune: assert property ( // RQ6
    !$stable(tuned_freq_mhz) |-> tune_done)
    else $error("frequency changed without a tune");

  a_tune_result: assert property ( // RQ1
    wr_commit && (idx == IDX_CTRL) && pwdata[CTRL_TUNE_BIT] |=>
      tune_done && tuned_freq_mhz == $past(tif.freq))
    else $error("tune result not captured");

  a_defaults_kept: assert property ( // RQ9 RQ10
    !st.loaded && !nv_cfg_valid |=> st.fine == RST_GRID_FINE && st.coarse == RST_GRID_COARSE)
    else $error("defaults not in place after reset");

  a_nv_restore: assert property ( // RQ11
    !st.loaded && nv_cfg_valid |=>
      st.coarse == $past(nv_grid_spacing_coarse) && st.thz == $past(nv_first_channel_thz))
    else $error("saved configuration not loaded");

  a_output_gate: assert property ( // RQ18
    ##1 optical_output_enabled ==
      $past(st.sw_en && hardware_output_disable_n &&
        !(st.shutdown_on_fatal && fatal_condition_active)))
    else $error("output enable does not follow its inputs");

  c_refused_write: cover property (psel && penable && pready && pwrite && pslverr);
  c_tune_run: cover property (tune_done ##1 !tune_done);
  c_fine_negative: cover property (wr_commit && (idx == IDX_GRID_FINE) && pwdata[15]);
  c_fatal_off: cover property (st.sw_en && st.shutdown_on_fatal && fatal_condition_active ##1
    !optical_output_enabled);
endmodule : gfc_regs

// [logic/gfc_tune_if.sv]
`timescale 1ns/1ps
interface gfc_tune_if;
  logic [15:0] coarse, fine, thz, tenths, mhz, chan_lo, chan_hi, fto;
  logic [63:0] freq;
  modport src (output coarse, fine, thz, tenths, mhz, chan_lo, chan_hi, fto, input freq);
  modport calc (input coarse, fine, thz, tenths, mhz, chan_lo, chan_hi, fto, output freq);
endinterface : gfc_tune_if

// [tb/gfc_host_model.sv]
`timescale 1ns/1ps
module gfc_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int waits;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // one apb transfer, request held until pready is seen high or 16 access cycles pass
  task xfer(input logic w, input logic [9:0] i, input logic [15:0] d,
            output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    waits = 0;
    do begin
      @(posedge pclk);
      waits++;
    end while (pready !== 1'b1 && waits < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask : xfer
endmodule : gfc_host_model

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  import gfc_pkg::*;
  localparam logic [9:0] CIX [5] = '{IDX_GRID_COARSE, IDX_FCF_THZ, IDX_FCF_TENTHS,
                                     IDX_GRID_FINE, IDX_FCF_MHZ};
  localparam logic [15:0] DEF [5] = '{RST_GRID_COARSE, RST_FCF_THZ, RST_FCF_TENTHS,
                                      RST_GRID_FINE, RST_FCF_MHZ};
  // sw_en, shutdown on fatal, pin, fatal, expected enable
  localparam logic [4:0] TBL [5] = '{5'b10101, 5'b00100, 5'b10000, 5'b11110, 5'b10111};
  logic pclk, presetn, dis_n, fatal, nv_ok, e;
  logic psel, penable, pwrite, pready, pslverr, en, tdone;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] freq, fx;
  logic [15:0] nv [5];
  logic [15:0] mdl [5];
  logic [15:0] ch_lo, ch_hi, fto, v;
  int err_total, check_count;

  gfc_host_model gfc_host_model_inst (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  gfc_regs gfc_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hardware_output_disable_n(dis_n), .fatal_condition_active(fatal),
    .nv_cfg_valid(nv_ok), .nv_grid_spacing_coarse(nv[0]), .nv_grid_spacing_fine(nv[3]),
    .nv_first_channel_thz(nv[1]), .nv_first_channel_ghz_tenths(nv[2]),
    .nv_first_channel_mhz(nv[4]), .optical_output_enabled(en),
    .tuned_freq_mhz(freq), .tune_done(tdone));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task tally_and_finish();
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  task acc(input logic w, input logic [9:0] i, input logic [15:0] d, input logic xe);
    gfc_host_model_inst.xfer(w, i, d, rd, e);
    chk(64'(e), 64'(xe));
    chk(64'(gfc_host_model_inst.waits), 64'h1);
    if (xe) chk(64'(rd), 64'h0);
  endtask : acc

  task rdchk(input logic [9:0] i, input logic [15:0] x);
    acc(1'b0, i, 16'h0000, 1'b0);
    chk(64'(rd), 64'(x));
  endtask : rdchk

  task rst(input logic nvv);
    presetn <= 1'b0;
    nv_ok <= nvv;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : rst

  function automatic logic [63:0] fm();
    longint s;
    s = longint'($signed(mdl[0])) * 100 + longint'($signed(mdl[3]));
    return 64'((longint'({ch_hi, ch_lo}) - 1) * s + longint'(mdl[1]) * 1000000
      + longint'(mdl[2]) * 100 + longint'(mdl[4]) + longint'($signed(fto)));
  endfunction : fm

  function automatic logic [15:0] rv(int k);
    return (k == 3) ? 16'($urandom_range(198)) - 16'h0063 : 16'($urandom);
  endfunction : rv

  task tune();
    acc(1'b1, IDX_CTRL, 16'h0004, 1'b0);
    @(posedge pclk);
    chk(64'(tdone), 64'h1);
    @(posedge pclk);
    chk(freq, fm());
  endtask : tune

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    presetn = 1'b0;
    dis_n = 1'b1;
    fatal = 1'b0;
    nv_ok = 1'b0;
    void'($urandom(52));
    for (int k = 0; k < 5; k++) nv[k] = rv(k);
    rst(1'b0);
    mdl = DEF;
    for (int k = 0; k < 5; k++) rdchk(CIX[k], mdl[k]);
    for (int k = 4; k >= 0; k--) begin
      v = rv(k);
      acc(1'b1, CIX[k], v, 1'b0);
      mdl[k] = v;
    end
    for (int k = 0; k < 5; k++) rdchk(CIX[k], mdl[k]);
    for (int t = 0; t < 2; t++) begin
      ch_lo = (t == 0) ? 16'($urandom_range(1, 90)) : 16'h0000;
      ch_hi = (t == 0) ? 16'($urandom_range(0, 3)) : 16'h0000;
      fto = 16'($urandom);
      acc(1'b1, IDX_CHAN_LO, ch_lo, 1'b0);
      acc(1'b1, IDX_CHAN_HI, ch_hi, 1'b0);
      acc(1'b1, IDX_FINE_TUNE, fto, 1'b0);
      tune();
      fx = fm();
      v = rv(0);
      acc(1'b1, IDX_GRID_COARSE, v, 1'b0);
      mdl[0] = v;
      repeat (2) @(posedge pclk);
      chk(freq, fx);
      tune();
    end
    for (int k = 0; k < 5; k++) begin
      dis_n <= TBL[k][2];
      fatal <= TBL[k][1];
      acc(1'b1, IDX_CTRL, {14'h0000, TBL[k][3], TBL[k][4]}, 1'b0);
      repeat (2) @(posedge pclk);
      chk(64'(en), 64'(TBL[k][0]));
      v = rv(k);
      acc(1'b1, CIX[k], v, TBL[k][0]);
      if (!TBL[k][0]) mdl[k] = v;
      rdchk(CIX[k], mdl[k]);
      rdchk(IDX_STATUS, {14'h0000, TBL[k][0], TBL[k][0]});
      acc(1'b1, IDX_STATUS, 16'h0001, 1'b0);
    end
    dis_n <= 1'b1;
    fatal <= 1'b0;
    acc(1'b1, IDX_CTRL, 16'h0000, 1'b0);
    acc(1'b0, 10'h3FF, 16'h0000, 1'b1);
    rst(1'b1);
    mdl = nv;
    for (int k = 0; k < 5; k++) rdchk(CIX[k], mdl[k]);
    tally_and_finish();
  end
endmodule : tb
